/* hdl/svg_pkg.sv */
package svg_pkg;
    // Coordinate format
    localparam int COORD_WIDTH = 16;
    localparam logic signed [15:0] CENTRE_COORD = 16'sh0000;
    // Command kinds
    typedef enum logic [1:0] {
        svg_cmd_jump,
        svg_cmd_mark,
        svg_cmd_close
    } svg_cmd_type;
    // Command word layout: kind, x, y
    localparam int CMD_KIND_LSB = 32;
    localparam int CMD_X_LSB    = 16;
    localparam int CMD_Y_LSB    = 0;
    localparam int CMD_WIDTH    = 34;
    // Output pacing
    localparam int CLK_FREQ_HZ    = 200_000_000;
    localparam int MIN_OUT_GAP_PS = 2_800_000;
    localparam int CLK_PERIOD_PS  = 1_000_000_000 / (CLK_FREQ_HZ / 1000);
    localparam int OUT_GAP_CYCLES =
        (MIN_OUT_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_CNT_WIDTH  = 10;
    // Ring buffers
    localparam int RING_DEPTH_LOG2 = 6;
endpackage

/* hdl/svg_ring_mem.sv */
`timescale 1ns/1ps
// Two command rings in one memory; the ring select is the top address bit
module svg_ring_mem
    import svg_pkg::*;
#(
    parameter int DATA_WIDTH = CMD_WIDTH,
    parameter int ADDR_WIDTH = RING_DEPTH_LOG2 + 1
) (
    // Clock
    input  wire logic                  clk,
    // Write port
    input  wire logic                  wr_en,
    input  wire logic [ADDR_WIDTH-1:0] wr_addr,
    input  wire logic [DATA_WIDTH-1:0] wr_data,
    // Read port
    input  wire logic [ADDR_WIDTH-1:0] rd_addr,
    output logic      [DATA_WIDTH-1:0] rd_data
);
    logic [DATA_WIDTH-1:0] mem [2**ADDR_WIDTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* hdl/svg_vector_gen.sv */
`timescale 1ns/1ps
module svg_vector_gen
    import svg_pkg::*;
#(
    parameter int DEPTH_LOG2 = RING_DEPTH_LOG2,
    parameter int GAP_CYCLES = OUT_GAP_CYCLES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // Host command load
    input  wire logic                    cmd_valid,
    input  wire logic [CMD_WIDTH-1:0]    cmd_data,
    output logic                         cmd_ready,
    input  wire logic                    cmd_commit,
    // Velocity settings
    input  wire logic [15:0]             set_jump_velocity,
    input  wire logic [15:0]             set_mark_velocity,
    // Control
    input  wire logic                    start_pin,
    // Status
    output logic                         busy,
    // Scan head position stream
    output logic signed [15:0]           pos_x,
    output logic signed [15:0]           pos_y,
    output logic                         pos_strobe,
    // Laser control
    output logic                         laser_gate,
    output logic                         qswitch_mod_n
);
    initial begin
        if (DEPTH_LOG2 < 1 || GAP_CYCLES < 1 || GAP_CYCLES >= 2**GAP_CNT_WIDTH) begin
            $error("svg_vector_gen: unsupported parameter value");
        end
    end

    localparam int AW = DEPTH_LOG2 + 1;

    typedef enum logic [2:0] {
        svg_idle,
        svg_fetch,
        svg_load,
        svg_step,
        svg_gap
    } svg_state_type;

    // Start pin synchroniser
    logic start_meta;
    logic start_sync;
    logic start_prev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_prev <= 1'b0;
        end else begin
            start_meta <= start_pin;
            start_sync <= start_meta;
            start_prev <= start_sync;
        end
    end

    // Ring bookkeeping
    logic                  fill_ring;
    logic                  run_ring;
    logic [DEPTH_LOG2-1:0] wr_ptr;
    logic [DEPTH_LOG2-1:0] rd_ptr;
    logic [DEPTH_LOG2:0]   ring_count [2];
    logic [DEPTH_LOG2:0]   wr_count;
    logic                  pending;
    logic                  next_fill_ring;
    logic                  next_run_ring;
    logic [DEPTH_LOG2-1:0] next_wr_ptr;
    logic [DEPTH_LOG2-1:0] next_rd_ptr;
    logic [DEPTH_LOG2:0]   next_ring_count [2];
    logic [DEPTH_LOG2:0]   next_wr_count;
    logic                  next_pending;
    logic                  wr_fire;
    logic [CMD_WIDTH-1:0]  rd_data;

    // Motion state
    svg_state_type        state;
    svg_state_type        next_state;
    logic signed [15:0]   cur_x;
    logic signed [15:0]   cur_y;
    logic signed [15:0]   tgt_x;
    logic signed [15:0]   tgt_y;
    logic [15:0]          step_size;
    logic                 laser_on;
    logic [GAP_CNT_WIDTH-1:0] gap_cnt;
    logic signed [15:0]   next_cur_x;
    logic signed [15:0]   next_cur_y;
    logic signed [15:0]   next_tgt_x;
    logic signed [15:0]   next_tgt_y;
    logic [15:0]          next_step_size;
    logic                 next_laser_on;
    logic [GAP_CNT_WIDTH-1:0] next_gap_cnt;
    logic                 next_busy;
    logic                 next_strobe;

    // Step arithmetic on 18 bits so no 16-bit overflow occurs
    logic signed [17:0]   dx;
    logic signed [17:0]   dy;
    logic [17:0]          adx;
    logic [17:0]          ady;
    logic [17:0]          lmax;
    logic signed [17:0]   sx;
    logic signed [17:0]   sy;
    logic signed [17:0]   nx;
    logic signed [17:0]   ny;
    logic                 last_step;

    svg_cmd_type rd_kind;
    assign rd_kind = svg_cmd_type'(rd_data[CMD_KIND_LSB +: 2]);

    assign wr_fire = cmd_valid && cmd_ready;

    svg_ring_mem #(
        .DATA_WIDTH (CMD_WIDTH),
        .ADDR_WIDTH (AW)
    ) u_mem (
        .clk     (clk),
        .wr_en   (wr_fire),
        .wr_addr ({fill_ring, wr_ptr}),
        .wr_data (cmd_data),
        .rd_addr ({run_ring, rd_ptr}),
        .rd_data (rd_data)
    );

    always_comb begin
        dx   = 18'(tgt_x) - 18'(cur_x);
        dy   = 18'(tgt_y) - 18'(cur_y);
        adx  = dx[17] ? 18'(-dx) : 18'(dx);
        ady  = dy[17] ? 18'(-dy) : 18'(dy);
        lmax = (adx > ady) ? adx : ady;
        last_step = (lmax <= 18'(step_size));
        // Dominant axis moves by step size, the other in proportion
        if (lmax == 18'h00000) begin
            sx = 18'sh00000;
            sy = 18'sh00000;
        end else begin
            // Keep the product signed so negative deltas divide correctly
            sx = 18'((36'(dx) * signed'(36'(step_size))) / signed'(36'(lmax)));
            sy = 18'((36'(dy) * signed'(36'(step_size))) / signed'(36'(lmax)));
        end
        nx = last_step ? 18'(tgt_x) : 18'(cur_x) + sx;
        ny = last_step ? 18'(tgt_y) : 18'(cur_y) + sy;
    end

    always_comb begin
        next_fill_ring  = fill_ring;
        next_run_ring   = run_ring;
        next_wr_ptr     = wr_ptr;
        next_rd_ptr     = rd_ptr;
        next_ring_count = ring_count;
        next_wr_count   = wr_count;
        next_pending    = pending;
        next_state      = state;
        next_cur_x      = cur_x;
        next_cur_y      = cur_y;
        next_tgt_x      = tgt_x;
        next_tgt_y      = tgt_y;
        next_step_size  = step_size;
        next_laser_on   = laser_on;
        next_gap_cnt    = gap_cnt;
        next_busy       = busy;
        next_strobe     = 1'b0;
        // Fill side: writes into the ring that is not running
        if (wr_fire) begin
            next_wr_ptr   = wr_ptr + 1'b1;
            next_wr_count = wr_count + 1'b1;
        end
        if (cmd_commit && !pending && (wr_count != '0 || wr_fire)) begin
            next_ring_count[fill_ring] = wr_fire ? wr_count + 1'b1 : wr_count;
            next_pending   = 1'b1;
            next_fill_ring = !fill_ring;
            next_wr_ptr    = '0;
            next_wr_count  = '0;
        end
        case (state)
            svg_idle: begin
                next_laser_on = 1'b0;
                if (pending && start_sync && !start_prev) begin
                    next_run_ring = !fill_ring;
                    next_rd_ptr   = '0;
                    next_pending  = 1'b0;
                    next_busy     = 1'b1;
                    next_state    = svg_fetch;
                end
            end
            svg_fetch: begin
                next_state = svg_load;
            end
            svg_load: begin
                next_tgt_x = signed'(rd_data[CMD_X_LSB +: COORD_WIDTH]);
                next_tgt_y = signed'(rd_data[CMD_Y_LSB +: COORD_WIDTH]);
                next_rd_ptr = rd_ptr + 1'b1;
                next_ring_count[run_ring] = ring_count[run_ring] - 1'b1;
                if (rd_kind == svg_cmd_mark) begin
                    next_step_size = set_mark_velocity;
                    if (!laser_on) begin
                        next_laser_on = 1'b1;
                    end
                end else begin
                    next_step_size = set_jump_velocity;
                    next_laser_on  = 1'b0;
                end
                if (rd_kind == svg_cmd_close) begin
                    next_tgt_x = CENTRE_COORD;
                    next_tgt_y = CENTRE_COORD;
                end
                if (next_step_size == 16'h0000) begin
                    next_step_size = 16'h0001;
                end
                next_state = svg_step;
            end
            svg_step: begin
                // Segment starts from the held position
                next_cur_x  = 16'(nx);
                next_cur_y  = 16'(ny);
                next_strobe = 1'b1;
                next_gap_cnt = GAP_CNT_WIDTH'(GAP_CYCLES - 1);
                next_state  = svg_gap;
            end
            svg_gap: begin
                if (gap_cnt > 1) begin
                    next_gap_cnt = gap_cnt - 1'b1;
                end else if (cur_x != tgt_x || cur_y != tgt_y) begin
                    next_state = svg_step;
                end else if (ring_count[run_ring] != '0) begin
                    next_state = svg_fetch;
                end else begin
                    next_laser_on = 1'b0;
                    next_busy     = 1'b0;
                    next_state    = svg_idle;
                end
            end
            default: begin
                next_state = svg_idle;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fill_ring     <= 1'b0;
            run_ring      <= 1'b1;
            wr_ptr        <= '0;
            rd_ptr        <= '0;
            ring_count[0] <= '0;
            ring_count[1] <= '0;
            wr_count      <= '0;
            pending       <= 1'b0;
            state         <= svg_idle;
            cur_x         <= CENTRE_COORD;
            cur_y         <= CENTRE_COORD;
            tgt_x         <= CENTRE_COORD;
            tgt_y         <= CENTRE_COORD;
            step_size     <= 16'h0001;
            laser_on      <= 1'b0;
            gap_cnt       <= '0;
            busy          <= 1'b0;
            pos_strobe    <= 1'b0;
            pos_x         <= CENTRE_COORD;
            pos_y         <= CENTRE_COORD;
            laser_gate    <= 1'b0;
            qswitch_mod_n <= 1'b1;
            cmd_ready     <= 1'b0;
        end else begin
            fill_ring     <= next_fill_ring;
            run_ring      <= next_run_ring;
            wr_ptr        <= next_wr_ptr;
            rd_ptr        <= next_rd_ptr;
            ring_count    <= next_ring_count;
            wr_count      <= next_wr_count;
            pending       <= next_pending;
            state         <= next_state;
            cur_x         <= next_cur_x;
            cur_y         <= next_cur_y;
            tgt_x         <= next_tgt_x;
            tgt_y         <= next_tgt_y;
            step_size     <= next_step_size;
            laser_on      <= next_laser_on;
            gap_cnt       <= next_gap_cnt;
            busy          <= next_busy;
            pos_strobe    <= next_strobe;
            pos_x         <= next_cur_x;
            pos_y         <= next_cur_y;
            laser_gate    <= next_laser_on;
            qswitch_mod_n <= !next_laser_on;
            // Fill ring accepts while it is not waiting to run and has room
            cmd_ready     <= !next_pending &&
                             (next_wr_count < (DEPTH_LOG2+1)'(2**DEPTH_LOG2 - 1));
        end
    end
endmodule

/* bench/svg_vector_gen_checker.sv */
`timescale 1ns/1ps
module svg_vector_gen_checker
    import svg_pkg::*;
#(
    parameter int GAP_CYCLES = OUT_GAP_CYCLES
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               sys_rst,
    // Control and stream
    input wire logic               start_pin,
    input wire logic               busy,
    input wire logic signed [15:0] pos_x,
    input wire logic signed [15:0] pos_y,
    input wire logic               pos_strobe,
    input wire logic               laser_gate,
    input wire logic               qswitch_mod_n
);
    logic [15:0] gap_cnt;
    logic [15:0] next_gap_cnt;

    // Strobe period in cycles as seen at the next strobe, saturating
    always_comb begin
        next_gap_cnt = (gap_cnt == 16'hffff) ? gap_cnt : gap_cnt + 16'h0001;
        if (sys_rst || pos_strobe) begin
            next_gap_cnt = sys_rst ? 16'hffff : 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        gap_cnt <= next_gap_cnt;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_qswitch_inverse: assert property (qswitch_mod_n != laser_gate)
        else $error("qswitch not inverse of laser gate");
    a_strobe_gap: assert property (pos_strobe |-> gap_cnt >= GAP_CYCLES)
        else $error("position strobes too close");
    a_pos_on_strobe: assert property (!$past(sys_rst) && ($changed(pos_x) || $changed(pos_y))
        |-> pos_strobe)
        else $error("position changed without strobe");
    a_stream_busy: assert property (pos_strobe |-> busy || $past(busy))
        else $error("strobe outside a run");
    a_idle_dark: assert property (!busy |-> !laser_gate)
        else $error("laser on while idle");
    a_start_cause: assert property ($rose(busy) |-> $past(start_pin, 2))
        else $error("run began without start");
    a_first_step: assert property ($rose(busy) |-> ##[1:8] pos_strobe)
        else $error("no step after run start");
    a_reset_centre: assert property ($fell(sys_rst) |-> pos_x == 16'sh0000 && pos_y == 16'sh0000)
        else $error("position not centred after reset");
    a_laser_in_run: assert property ($rose(laser_gate) |-> busy)
        else $error("laser enabled outside a run");
endmodule

bind svg_vector_gen svg_vector_gen_checker #(.GAP_CYCLES(GAP_CYCLES)) i_checker (
    .clk(clk), .sys_rst(sys_rst), .start_pin(start_pin), .busy(busy), .pos_x(pos_x),
    .pos_y(pos_y), .pos_strobe(pos_strobe), .laser_gate(laser_gate),
    .qswitch_mod_n(qswitch_mod_n));

/* bench/svg_dac_model.sv */
`timescale 1ns/1ps
module svg_dac_model (
    // Clock
    input wire logic               clk,
    // Position stream and laser lines
    input wire logic signed [15:0] pos_x,
    input wire logic signed [15:0] pos_y,
    input wire logic               pos_strobe,
    input wire logic               laser_gate,
    input wire logic               qswitch_mod_n
);
    logic signed [15:0] q_x[$];
    logic signed [15:0] q_y[$];
    logic               q_gate[$];
    logic               q_qsw[$];

    // One converter update per strobe, signed 16-bit per axis
    always @(posedge clk) begin
        if (pos_strobe === 1'b1) begin
            q_x.push_back(pos_x);
            q_y.push_back(pos_y);
            q_gate.push_back(laser_gate);
            q_qsw.push_back(qswitch_mod_n);
        end
    end
endmodule

/* bench/test_scan_vector_generator.sv */
`timescale 1ns/1ps
module test_scan_vector_generator
    import svg_pkg::*;
;
    localparam int GAP = 4;
    logic                 clk;
    logic                 sys_rst;
    logic                 cmd_valid;
    logic [CMD_WIDTH-1:0] cmd_data;
    logic                 cmd_ready;
    logic                 cmd_commit;
    logic [15:0]          set_jump_velocity;
    logic [15:0]          set_mark_velocity;
    logic                 start_pin;
    logic                 busy;
    logic signed [15:0]   pos_x;
    logic signed [15:0]   pos_y;
    logic                 pos_strobe;
    logic                 laser_gate;
    logic                 qswitch_mod_n;
    int                   error_cnt = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    int                   ek[$];
    int                   ex[$];
    int                   ey[$];

    svg_vector_gen #(.GAP_CYCLES(GAP)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .cmd_commit(cmd_commit), .set_jump_velocity(set_jump_velocity),
        .set_mark_velocity(set_mark_velocity), .start_pin(start_pin), .busy(busy),
        .pos_x(pos_x), .pos_y(pos_y), .pos_strobe(pos_strobe), .laser_gate(laser_gate),
        .qswitch_mod_n(qswitch_mod_n));

    svg_dac_model i_dac (
        .clk(clk), .pos_x(pos_x), .pos_y(pos_y), .pos_strobe(pos_strobe),
        .laser_gate(laser_gate), .qswitch_mod_n(qswitch_mod_n));

    task automatic chk(input string what, input logic signed [31:0] seen,
                       input logic signed [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic int rnd16();
        logic [31:0] r;
        r = $urandom();
        return int'(signed'(r[15:0]));
    endfunction

    // Hold each word until the ring accepts it
    task automatic push(input int k, input int x, input int y);
        cmd_valid <= 1'b1;
        cmd_data <= {2'(k), 16'(x), 16'(y)};
        ek.push_back(k);
        ex.push_back(x);
        ey.push_back(y);
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
    endtask

    task automatic commit;
        cmd_valid <= 1'b0;
        cmd_commit <= 1'b1;
        @(posedge clk);
        cmd_commit <= 1'b0;
    endtask

    task automatic start_run;
        start_pin <= 1'b1;
        repeat (20) @(posedge clk);
        start_pin <= 1'b0;
    endtask

    task automatic wait_busy(input logic lvl);
        while (busy !== lvl) @(posedge clk);
    endtask

    // Reference stepping: dominant axis moves by the step, last step lands on target
    task automatic check_run(input int jv, input int mv);
        int cx, cy, k, tx, ty, s, dx, dy, ax, ay, n;
        cx = 0;
        cy = 0;
        do begin
            k = ek.pop_front();
            tx = (k == svg_cmd_close) ? 0 : ex.pop_front();
            ty = (k == svg_cmd_close) ? 0 : ey.pop_front();
            if (k == svg_cmd_close) begin
                void'(ex.pop_front());
                void'(ey.pop_front());
            end
            s = (k == svg_cmd_mark) ? mv : jv;
            s = (s == 0) ? 1 : s;
            dx = tx - cx;
            dy = ty - cy;
            ax = (dx < 0) ? -dx : dx;
            ay = (dy < 0) ? -dy : dy;
            n = (((ax > ay) ? ax : ay) + s - 1) / s;
            n = (n == 0) ? 1 : n;
            for (int i = 1; i <= n; i++) begin
                if (i_dac.q_x.size() == 0) begin
                    chk("strobe count", 0, 1);
                    return;
                end
                if (i < n && ax >= ay) begin
                    chk("pos_x step", i_dac.q_x[0], cx + ((dx < 0) ? -i * s : i * s));
                end else if (i < n) begin
                    chk("pos_y step", i_dac.q_y[0], cy + ((dy < 0) ? -i * s : i * s));
                end else begin
                    chk("pos_x end", i_dac.q_x[0], tx);
                    chk("pos_y end", i_dac.q_y[0], ty);
                end
                chk("laser_gate", i_dac.q_gate.pop_front(), k == svg_cmd_mark);
                chk("qswitch_mod_n", i_dac.q_qsw.pop_front(), k != svg_cmd_mark);
                void'(i_dac.q_x.pop_front());
                void'(i_dac.q_y.pop_front());
            end
            cx = tx;
            cy = ty;
        end while (k != svg_cmd_close);
        chk("strobe count", i_dac.q_x.size(), 0);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_data = '0;
        cmd_commit = 1'b0;
        set_jump_velocity = 16'h0000;
        set_mark_velocity = 16'h0000;
        start_pin = 1'b0;
        void'($urandom(32'h67b9));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        push(svg_cmd_jump, 3, -2);
        push(svg_cmd_mark, 7, 5);
        push(svg_cmd_close, 0, 0);
        commit();
        repeat (20) @(posedge clk);
        chk("idle strobes", i_dac.q_x.size(), 0);
        chk("cmd_ready", cmd_ready, 0);
        start_run();
        wait_busy(1'b1);
        // Fill the second ring while the first one streams
        push(svg_cmd_jump, 32767, -32768);
        repeat (2) push(svg_cmd_mark, rnd16(), rnd16());
        push(svg_cmd_jump, rnd16(), rnd16());
        push(svg_cmd_mark, -32768, 32767);
        push(svg_cmd_close, 0, 0);
        commit();
        chk("busy", busy, 1);
        wait_busy(1'b0);
        check_run(0, 0);
        chk("laser idle", laser_gate, 0);
        set_jump_velocity <= 16'(1500 + $urandom_range(2500));
        set_mark_velocity <= 16'(500 + $urandom_range(1000));
        start_run();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_run(int'(set_jump_velocity), int'(set_mark_velocity));
        push(svg_cmd_jump, 30000, -30000);
        push(svg_cmd_close, 0, 0);
        commit();
        start_run();
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("pos_x reset", pos_x, 0);
        chk("pos_y reset", pos_y, 0);
        chk("busy reset", busy, 0);
        complete_run();
    end
endmodule
